/* File: hdl/lstm_pkg.sv */
// Constants, modes and states of the line sensor trigger and mode controller.
// Assumes one 100 MHz system clock and a synchronous active-high reset.
// Overview of operation
// - Five modes: three internal, single-shot, external sync.
// - Modes work for storage and streaming alike.
// - Single-shot keeps sensor flushed; integration up to 500us.
// - Rising trigger edge meaning depends on mode.
// - Input pulse stretched 50 ns; source holds 8 ns.
// - Trigger output is one 500 ns high pulse.
// - Output pulse marks integration start, non-sync modes.
// - Programmable lead 0..1849us in shutter operation.
// - Mode, integration, lead changeable while running.
// - Shutter below 3710us integration, else non-shutter.
package lstm_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned US_NS         = 1000;
	localparam int unsigned CYC_PER_US    = US_NS / CLK_PERIOD_NS;
	// Least times round up, so the stretch never comes out short
	localparam int unsigned STRETCH_NS    = 50;
	localparam int unsigned STRETCH_CYC   = (STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TRIG_OUT_NS   = 500;
	localparam int unsigned TRIG_OUT_CYC  = TRIG_OUT_NS / CLK_PERIOD_NS;
	localparam int unsigned TINT_W        = 26;
	localparam int unsigned LEAD_W        = 11;
	localparam logic [TINT_W-1:0] READOUT_US    = 26'h0000e7e;
	localparam logic [TINT_W-1:0] SINGLE_MAX_US = 26'h00001f4;
	localparam logic [TINT_W-1:0] TINT_MIN_US   = 26'h0000001;
	localparam logic [LEAD_W-1:0] LEAD_MAX_US   = 11'h739;
	typedef enum logic [2:0]
	{
		LSTM_SW_START  = 3'h0,
		LSTM_HW_START  = 3'h1,
		LSTM_HW_ENABLE = 3'h2,
		LSTM_SINGLE    = 3'h3,
		LSTM_EXT_SYNC  = 3'h4
	} lstm_mode_t;
	typedef enum logic [1:0]
	{
		LSTM_ST_WAIT = 2'h0,
		LSTM_ST_RUN  = 2'h1
	} lstm_state_t;
endpackage : lstm_pkg

/* File: hdl/lstm_pulse.sv */
// Retriggerable fixed-length pulse: busy stays high LEN cycles after the
// last start. Assumes start comes from logic on the same clock.
`timescale 1ns/1ps
module lstm_pulse
#(
	parameter int unsigned LEN = 5
)
(
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic start,
	output logic      busy
);
	localparam int unsigned W = $clog2(LEN + 1);
	logic [W-1:0] cnt_reg;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			cnt_reg <= '0;
			busy    <= 1'h0;
		end
		else if (start)
		begin
			cnt_reg <= W'(LEN - 1);
			busy    <= 1'h1;
		end
		else if (cnt_reg != '0)
		begin
			cnt_reg <= cnt_reg - 1'h1;
			busy    <= 1'h1;
		end
		else
			busy    <= 1'h0;
	end
endmodule : lstm_pulse

/* File: hdl/lstm_ctrl.sv */
// Acquisition timing controller: frame sequencing in microsecond steps,
// trigger input conditioning and trigger output generation.
// Assumes host settings arrive as plain ports on clk_sys; trig_in_pin is
// asynchronous and is synchronised here.
`timescale 1ns/1ps
module lstm_ctrl
#(
	parameter int unsigned US_CYCLES = lstm_pkg::CYC_PER_US
)
(
	input  wire logic                        clk_sys,
	input  wire logic                        rst,
	input  wire logic                        trig_in_pin,
	input  wire lstm_pkg::lstm_mode_t        mode_sel,
	input  wire logic [lstm_pkg::TINT_W-1:0] tint_us,
	input  wire logic [lstm_pkg::LEAD_W-1:0] lead_us,
	input  wire logic                        sw_capture,
	input  wire logic                        stream_sel,
	output logic                             trig_out,
	output logic                             shutter_mode,
	output logic                             sensor_flush,
	output logic                             single_fault,
	output logic                             frame_busy,
	output logic                             integ_start,
	output logic                             integ_end,
	output logic                             frame_capture,
	output logic                             frame_to_stream
);
	localparam int unsigned TW = lstm_pkg::TINT_W;
	localparam int unsigned UW = $clog2(US_CYCLES + 1);

	logic              sync1_reg, sync2_reg, stretch, stretch_d_reg, edge_det;
	logic [UW-1:0]     us_cnt_reg;
	logic              tick_reg;
	lstm_pkg::lstm_state_t state_reg;
	lstm_pkg::lstm_mode_t  mode_reg;
	logic [TW-1:0]     tint_reg, pos_reg, integ_at, fire_at, lead_ext;
	logic [lstm_pkg::LEAD_W-1:0] lead_reg;
	logic              shutter_next, internal_sel, single_ok, go, frame_end;
	logic              pos_new_reg, ev_integ, ev_fire, armed_reg;
	logic [TW-1:0]     tint_eff;

	// two-flop synchroniser ahead of the stretcher
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			sync1_reg <= 1'h0;
			sync2_reg <= 1'h0;
		end
		else
		begin
			sync1_reg <= trig_in_pin;
			sync2_reg <= sync1_reg;
		end
	end

	lstm_pulse #(.LEN(lstm_pkg::STRETCH_CYC)) u_stretch
	(
		.clk_sys (clk_sys),
		.rst     (rst),
		.start   (sync2_reg),
		.busy    (stretch)
	);

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			stretch_d_reg <= 1'h0;
		else
			stretch_d_reg <= stretch;
	end
	assign edge_det = stretch && !stretch_d_reg;

	// Microsecond tick; all frame timing counts whole microseconds
	always_ff @(posedge clk_sys)
	begin
		if (rst || state_reg == lstm_pkg::LSTM_ST_WAIT || us_cnt_reg == UW'(US_CYCLES - 1))
			us_cnt_reg <= '0;
		else
			us_cnt_reg <= us_cnt_reg + 1'h1;
	end
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			tick_reg <= 1'h0;
		else
			tick_reg <= state_reg == lstm_pkg::LSTM_ST_RUN && us_cnt_reg == UW'(US_CYCLES - 1);
	end

	// sensor operation chosen from integration time
	assign tint_eff     = (tint_us < lstm_pkg::TINT_MIN_US) ? lstm_pkg::TINT_MIN_US : tint_us;
	assign shutter_next = tint_eff < lstm_pkg::READOUT_US;
	assign internal_sel = mode_sel == lstm_pkg::LSTM_SW_START
		|| mode_sel == lstm_pkg::LSTM_HW_START || mode_sel == lstm_pkg::LSTM_HW_ENABLE;
	// single-shot refused above the integration limit
	assign single_ok    = tint_eff <= lstm_pkg::SINGLE_MAX_US;

	// edge starts a frame in single-shot and sync modes
	always_comb
	begin
		go = 1'h0;
		if (internal_sel)
			go = 1'h1;
		else if (mode_sel == lstm_pkg::LSTM_SINGLE)
			go = edge_det && single_ok;
		else if (mode_sel == lstm_pkg::LSTM_EXT_SYNC)
			go = edge_det;
	end

	// Frame ends after readout (shutter) or after integration (non-shutter)
	assign frame_end = state_reg == lstm_pkg::LSTM_ST_RUN && tick_reg
		&& pos_reg == (shutter_mode ? lstm_pkg::READOUT_US : tint_reg) - 1'h1;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			state_reg <= lstm_pkg::LSTM_ST_WAIT;
		else
		begin
			case (state_reg)
				lstm_pkg::LSTM_ST_WAIT:
					if (go)
						state_reg <= lstm_pkg::LSTM_ST_RUN;
				lstm_pkg::LSTM_ST_RUN:
					if (frame_end)
						state_reg <= lstm_pkg::LSTM_ST_WAIT;
				default:
					state_reg <= lstm_pkg::LSTM_ST_WAIT;
			endcase
		end
	end

	// settings taken at each frame start so a frame stays consistent
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			mode_reg        <= lstm_pkg::LSTM_SW_START;
			tint_reg        <= lstm_pkg::TINT_MIN_US;
			lead_reg        <= '0;
			shutter_mode    <= 1'h1;
			frame_to_stream <= 1'h0;
		end
		else if (state_reg == lstm_pkg::LSTM_ST_WAIT && go)
		begin
			mode_reg        <= mode_sel;
			tint_reg        <= tint_eff;
			lead_reg        <= (lead_us > lstm_pkg::LEAD_MAX_US) ? lstm_pkg::LEAD_MAX_US : lead_us;
			shutter_mode    <= shutter_next;
			// destination tag only, timing is identical
			frame_to_stream <= stream_sel;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst || state_reg == lstm_pkg::LSTM_ST_WAIT)
			pos_reg <= '0;
		else if (tick_reg && !frame_end)
			pos_reg <= pos_reg + 1'h1;
	end
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			pos_new_reg <= 1'h0;
		else
			pos_new_reg <= (state_reg == lstm_pkg::LSTM_ST_WAIT && go) || (tick_reg && !frame_end);
	end

	// lead taken off integration start, clipped at frame start
	assign lead_ext = {{(TW - lstm_pkg::LEAD_W){1'h0}}, lead_reg};
	assign integ_at = shutter_mode ? lstm_pkg::READOUT_US - tint_reg : '0;
	assign fire_at  = (shutter_mode && integ_at > lead_ext) ? integ_at - lead_ext
		: (shutter_mode ? '0 : integ_at);
	assign ev_integ = pos_new_reg && pos_reg == integ_at;
	// sync mode fires at integration end instead
	assign ev_fire  = (mode_reg == lstm_pkg::LSTM_EXT_SYNC) ? frame_end
		: (pos_new_reg && pos_reg == fire_at);

	lstm_pulse #(.LEN(lstm_pkg::TRIG_OUT_CYC)) u_trig_out
	(
		.clk_sys (clk_sys),
		.rst     (rst),
		.start   (ev_fire),
		.busy    (trig_out)
	);

	// armed by an edge only while sw_capture is high; sw_capture low clears it
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			armed_reg <= 1'h0;
		else if (edge_det && mode_sel == lstm_pkg::LSTM_HW_START && sw_capture)
			armed_reg <= 1'h1;
		else if (!sw_capture || mode_sel != lstm_pkg::LSTM_HW_START)
			armed_reg <= 1'h0;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			integ_start   <= 1'h0;
			integ_end     <= 1'h0;
			frame_capture <= 1'h0;
		end
		else
		begin
			integ_start <= ev_integ;
			integ_end   <= frame_end;
			if (ev_integ)
			begin
				case (mode_reg)
					lstm_pkg::LSTM_HW_START:  frame_capture <= armed_reg;
					lstm_pkg::LSTM_HW_ENABLE: frame_capture <= stretch;
					lstm_pkg::LSTM_SINGLE:    frame_capture <= 1'h1;
					default:                  frame_capture <= sw_capture;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			sensor_flush <= 1'h0;
			single_fault <= 1'h0;
			frame_busy   <= 1'h0;
		end
		else
		begin
			// flush while waiting for the single shot
			sensor_flush <= mode_sel == lstm_pkg::LSTM_SINGLE
				&& !(state_reg == lstm_pkg::LSTM_ST_RUN || go);
			single_fault <= mode_sel == lstm_pkg::LSTM_SINGLE && !single_ok;
			frame_busy   <= state_reg == lstm_pkg::LSTM_ST_RUN || go;
		end
	end

	// Assertion helpers: length of the last high run of each pulse; the stretch
	// count saturates, as a held trigger level may last a whole frame
	logic [7:0] out_len_reg, str_len_reg;
	always_ff @(posedge clk_sys)
	begin
		out_len_reg <= rst ? 8'h00 : (trig_out ? out_len_reg + 8'h01 : 8'h00);
	end
	always_ff @(posedge clk_sys)
	begin
		if (rst || !stretch)
			str_len_reg <= 8'h00;
		else if (str_len_reg != 8'hff)
			str_len_reg <= str_len_reg + 8'h01;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_fire_same;
		integ_start ##0 $rose(trig_out);
	endsequence

	a_out_width: assert property ($fell(trig_out)
		|-> out_len_reg == 8'(lstm_pkg::TRIG_OUT_CYC))
		else $error("trigger output pulse not 500 ns");
	a_stretch_len: assert property ($fell(stretch)
		|-> str_len_reg >= 8'(lstm_pkg::STRETCH_CYC))
		else $error("input stretch shorter than 50 ns");
	a_trig_at_start: assert property (ev_integ && mode_reg != lstm_pkg::LSTM_EXT_SYNC
		&& lead_reg == '0 |=> s_fire_same)
		else $error("trigger output not at integration start");
	a_sync_end: assert property (integ_end && mode_reg == lstm_pkg::LSTM_EXT_SYNC
		|-> $rose(trig_out))
		else $error("sync mode trigger not at integration end");
	a_shutter_sel: assert property (integ_start && !shutter_mode |-> $past(pos_reg) == '0)
		else $error("non-shutter integration not at frame start");
	a_single_guard: assert property (state_reg == lstm_pkg::LSTM_ST_WAIT && edge_det
		&& mode_sel == lstm_pkg::LSTM_SINGLE && !single_ok |=> state_reg == lstm_pkg::LSTM_ST_WAIT)
		else $error("single shot started above integration limit");
	a_single_flush: assert property (mode_sel == lstm_pkg::LSTM_SINGLE && !go
		&& state_reg == lstm_pkg::LSTM_ST_WAIT ##1 mode_sel == lstm_pkg::LSTM_SINGLE |-> sensor_flush)
		else $error("sensor not flushed while waiting");
	a_hwen_capture: assert property (integ_start && mode_reg == lstm_pkg::LSTM_HW_ENABLE
		|-> frame_capture == $past(stretch))
		else $error("capture enable did not follow trigger level");
	a_param_take: assert property (state_reg == lstm_pkg::LSTM_ST_WAIT && go
		|=> mode_reg == $past(mode_sel) && tint_reg == $past(tint_eff))
		else $error("settings not taken at frame start");
endmodule : lstm_ctrl

/* File: tb/lstm_instr.sv */
// Model of an external instrument: sends trigger pulses, times trig_out.
// Assumes fire and hold come from the bench, changed at falling edges.
`timescale 1ns/1ps
module lstm_instr
(
	input  wire logic clk_sys,
	input  wire logic fire,
	input  wire logic hold,
	input  wire logic trig_out,
	output logic      trig_in_pin,
	output int        hi_len
);
	int cnt = 0;
	// pulse of a full clock period
	assign trig_in_pin = hold | fire;
	initial hi_len = 0;
	always @(posedge clk_sys)
	begin
		cnt <= trig_out ? cnt + 1 : 0;
		if (!trig_out && cnt != 0)
			hi_len <= cnt;
	end
endmodule : lstm_instr

/* File: tb/tb_lstm_ctrl.sv */
// Self-checking bench for lstm_ctrl with an instrument model on the trigger pins.
// Assumes 100 MHz; US_CYCLES is cut to 1 so a frame lasts 3710 cycles.
`timescale 1ns/1ps
module tb_lstm_ctrl;
	logic                        clk_sys = 0;
	logic                        rst = 1;
	logic                        fire = 0;
	logic                        hold = 0;
	lstm_pkg::lstm_mode_t        mode_sel = lstm_pkg::LSTM_SW_START;
	logic [lstm_pkg::TINT_W-1:0] tint_us = 26'h000000a;
	logic [lstm_pkg::LEAD_W-1:0] lead_us = 11'h000;
	logic                        sw_capture = 0;
	logic                        stream_sel = 0;
	logic                        trig_in_pin;
	logic                        trig_out;
	logic                        shutter_mode;
	logic                        sensor_flush;
	logic                        single_fault;
	logic                        frame_busy;
	logic                        integ_start;
	logic                        integ_end;
	logic                        frame_capture;
	logic                        frame_to_stream;
	logic [2:0]                  ev;
	int                          hi_len;
	int                          err_count = 0;
	int                          n_tests = 0;
	int                          cyc = 0;
	int                          seed = 8;
	assign ev = {integ_end, integ_start, trig_out};
	always #5 clk_sys = ~clk_sys;
	lstm_ctrl #(.US_CYCLES(1)) lstm_ctrl_i (.clk_sys(clk_sys), .rst(rst),
		.trig_in_pin(trig_in_pin), .mode_sel(mode_sel), .tint_us(tint_us),
		.lead_us(lead_us), .sw_capture(sw_capture), .stream_sel(stream_sel),
		.trig_out(trig_out), .shutter_mode(shutter_mode), .sensor_flush(sensor_flush),
		.single_fault(single_fault), .frame_busy(frame_busy), .integ_start(integ_start),
		.integ_end(integ_end), .frame_capture(frame_capture),
		.frame_to_stream(frame_to_stream));
	lstm_instr lstm_instr_i (.clk_sys(clk_sys), .fire(fire), .hold(hold),
		.trig_out(trig_out), .trig_in_pin(trig_in_pin), .hi_len(hi_len));
	task automatic print_verdict;
		$display("Tests %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict
	// Watchdog sized for about twenty frames
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 80000)
		begin
			err_count++;
			print_verdict();
		end
	end
	task automatic chk_bit(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e)
		begin
			err_count++;
			$display("CHECK FAILED %s exp %b got %b", nm, e, g);
		end
	endtask : chk_bit
	task automatic chk_num(input string nm, input int e, input int g);
		n_tests++;
		if (g != e)
		begin
			err_count++;
			$display("CHECK FAILED %s exp %0d got %0d", nm, e, g);
		end
	endtask : chk_num
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step
	// Waits for the event to be low first, so a level left over from the last
	// frame is not taken for a new one; returns just after the raising edge
	task automatic wait_ev(input int k);
		do
			step(1);
		while (ev[k] !== 1'h0);
		do
			step(1);
		while (ev[k] !== 1'h1);
	endtask : wait_ev
	task automatic pulse;
		@(negedge clk_sys);
		fire = 1;
		@(negedge clk_sys);
		fire = 0;
	endtask : pulse
	// Cycles by which the output leads integration start
	function automatic int exp_lead(input int t, input int l);
		return (l < 3710 - t) ? l : 3710 - t;
	endfunction : exp_lead
	initial
	begin
		int t;
		int l;
		int d;
		step(10);
		chk_bit("busy_rst", 1'b0, frame_busy);
		chk_bit("shut_rst", 1'b1, shutter_mode);
		@(negedge clk_sys);
		rst = 0;
		for (int k = 0; k < 3; k++)
		begin
			@(negedge clk_sys);
			t = (k < 2) ? 10 : {$random(seed)} % 1000 + 1;
			l = (k == 0) ? 0 : (k == 1) ? 1849 : {$random(seed)} % 1850;
			tint_us = 26'(t);
			lead_us = 11'(l);
			stream_sel = 1'($random(seed));
			sw_capture = 1'($random(seed));
			wait_ev(2);
			wait_ev(0);
			d = 0;
			while (integ_start !== 1'b1)
			begin
				step(1);
				d++;
			end
			chk_num("lead", exp_lead(t, l), d);
			chk_bit("shutter", 1'b1, shutter_mode);
			chk_bit("capture", sw_capture, frame_capture);
			chk_bit("stream", stream_sel, frame_to_stream);
			step(60);
			chk_num("pulse_len", lstm_pkg::TRIG_OUT_CYC, hi_len);
		end
		@(negedge clk_sys);
		tint_us = 26'(3710 + {$random(seed)} % 50);
		wait_ev(2);
		wait_ev(1);
		chk_bit("trig_start", 1'b1, trig_out);
		chk_bit("non_shutter", 1'b0, shutter_mode);
		@(negedge clk_sys);
		mode_sel = lstm_pkg::LSTM_SINGLE;
		// Zero lead, so the output pulse still stands at integration start
		lead_us = 11'h000;
		// single shot only with integration up to 500 us
		tint_us = lstm_pkg::SINGLE_MAX_US;
		wait_ev(2);
		step(3);
		chk_bit("flush", 1'b1, sensor_flush);
		chk_bit("fault_ok", 1'b0, single_fault);
		pulse();
		step(6);
		chk_bit("short_trig", 1'b1, frame_busy);
		wait_ev(1);
		chk_bit("single_trig", 1'b1, trig_out);
		chk_bit("single_cap", 1'b1, frame_capture);
		@(negedge clk_sys);
		tint_us = lstm_pkg::SINGLE_MAX_US + 26'h0000001;
		wait_ev(2);
		step(3);
		chk_bit("fault", 1'b1, single_fault);
		pulse();
		step(10);
		chk_bit("refused", 1'b0, frame_busy);
		@(negedge clk_sys);
		mode_sel = lstm_pkg::LSTM_EXT_SYNC;
		tint_us = 26'h0000014;
		sw_capture = 1'($random(seed));
		pulse();
		wait_ev(1);
		chk_bit("sync_start", 1'b0, trig_out);
		chk_bit("sync_cap", sw_capture, frame_capture);
		@(negedge clk_sys);
		mode_sel = lstm_pkg::LSTM_HW_START;
		sw_capture = 0;
		wait_ev(2);
		chk_bit("sync_end", 1'b1, trig_out);
		wait_ev(1);
		chk_bit("unarmed", 1'b0, frame_capture);
		@(negedge clk_sys);
		sw_capture = 1;
		pulse();
		wait_ev(1);
		chk_bit("armed", 1'b1, frame_capture);
		@(negedge clk_sys);
		mode_sel = lstm_pkg::LSTM_HW_ENABLE;
		hold = 1;
		wait_ev(2);
		wait_ev(1);
		chk_bit("enabled", 1'b1, frame_capture);
		@(negedge clk_sys);
		hold = 0;
		wait_ev(1);
		chk_bit("disabled", 1'b0, frame_capture);
		print_verdict();
	end
endmodule : tb_lstm_ctrl
